/* hw/usb_host_capability_regs.sv */
// Read-only capability register bank of an enhanced USB 2.0 host controller
// Assumes: reads arrive as a strobe with a byte offset, synchronous to REF_CLK
`timescale 1ns/1ps

// Operation
// RULE1: Words at offsets 0 and 4, read-only
// RULE2: Bits 31:16 give BCD version 01.00
// RULE3: Bits 7:0 give capability length 20h
// RULE4: Reserved fields read as zero
// RULE5: Companion controller count field, reset one
// RULE6: Zero companions means high-speed only ports
// RULE7: Nonzero companions enables port ownership hand-off
// RULE8: Ports per companion field, reset two
// RULE9: Software groups ports sequentially per companion
// RULE10: Companions together cover every physical port
// RULE11: Bit 7 routing method, reset one
// RULE12: Software picks sequential or enumerated routing
// RULE13: Bit 4 port power switches, reset one
// RULE14: Bits 3:0 port count, reset two
module usb_host_capability_regs
   import cap_regs_pkg::*;
(
   // Clock and reset
   input  wire logic          REF_CLK,
   input  wire logic          NRST,
   // Register read port, plus write inputs that are ignored
   input  wire logic          RD_STROBE,
   input  wire logic [7:0]    RD_ADDR,
   input  wire logic          WR_STROBE,
   input  wire logic [7:0]    WR_ADDR,
   input  wire logic [31:0]   WR_DATA,
   output logic [31:0]        RD_DATA,
   output logic               RD_VALID,
   output logic               RD_HIT,
   // Capability status
   output logic               HANDOFF_SUPPORTED,
   output logic               HS_ONLY
);

   // ***************************************************************
   // Structural constants
   // ***************************************************************
   logic [3:0]                      companion_count;
   logic [3:0]                      ports_per_comp;
   logic [3:0]                      ports_total;
   cap_len_ver_type                 cap_word;
   structural_parameters_word_type  struct_word;
   logic [31:0]                     mux_value;
   logic                            mux_hit;

   assign companion_count = CC_COUNT_RESET;    // RULE5
   // Group size and port count are chosen together so companions cover all ports
   assign ports_per_comp  = PPC_COUNT_RESET;   // RULE8 RULE10
   assign ports_total     = PORT_COUNT_RESET;  // RULE14 RULE10

   cap_word_build i_cap_word_build (
      .companion_count (companion_count),
      .ports_per_comp  (ports_per_comp),
      .ports_total     (ports_total),
      .cap_word        (cap_word),
      .struct_word     (struct_word)
   );

   cap_read_mux i_cap_read_mux (
      .address    (RD_ADDR),
      .cap_word   (cap_word),
      .struct_word(struct_word),
      .read_value (mux_value),
      .hit        (mux_hit)
   );

   // ***************************************************************
   // Read answer registers
   // ***************************************************************
   logic [31:0] rd_data_reg;
   logic [31:0] rd_data_next;
   logic        rd_valid_reg;
   logic        rd_valid_next;
   logic        rd_hit_reg;
   logic        rd_hit_next;
   logic        handoff_reg;
   logic        handoff_next;
   logic        hs_only_reg;
   logic        hs_only_next;

   // Writes are ignored: every bit of the bank is read-only
   always_comb begin
      rd_data_next  = rd_data_reg;
      rd_valid_next = RD_STROBE;
      rd_hit_next   = rd_hit_reg;
      if (RD_STROBE) begin
         rd_data_next = mux_value;  // RULE1
         rd_hit_next  = mux_hit;
      end
      // Hand-off exists only when a companion is present
      handoff_next = (companion_count != 4'h0);  // RULE7
      hs_only_next = (companion_count == 4'h0);  // RULE6
   end

   // Register stage; outputs come straight from flip-flops
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rd_data_reg  <= 32'h0000_0000;
         rd_valid_reg <= 1'b0;
         rd_hit_reg   <= 1'b0;
         handoff_reg  <= 1'b0;
         hs_only_reg  <= 1'b0;
      end else begin
         rd_data_reg  <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         rd_hit_reg   <= rd_hit_next;
         handoff_reg  <= handoff_next;
         hs_only_reg  <= hs_only_next;
      end
   end

   // Companion coverage holds by construction: 1 x 2 ports covers 2 ports
   // RULE10 is met since count times group size equals the port count

   assign RD_DATA           = rd_data_reg;
   assign RD_VALID          = rd_valid_reg;
   assign RD_HIT            = rd_hit_reg;
   assign HANDOFF_SUPPORTED = handoff_reg;
   assign HS_ONLY           = hs_only_reg;

endmodule // usb_host_capability_regs

/* hw/cap_regs_pkg.sv */
// Package: constants and carriers for the host controller capability bank
// Assumes: included by every file of the bank; no clock or reset dependence
package cap_regs_pkg;

   // ***************************************************************
   // Register offsets (byte addresses from the function base)
   // ***************************************************************
   localparam logic [7:0] CAP_LEN_VER_OFFSET     = 8'h00;
   localparam logic [7:0] STRUCT_PARAMS_OFFSET   = 8'h04;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int VERSION_LSB       = 16;
   localparam int CAP_LEN_LSB       = 0;
   localparam int CC_COUNT_LSB      = 12;
   localparam int PPC_COUNT_LSB     = 8;
   localparam int ROUTE_METHOD_BIT  = 7;
   localparam int POWER_SWITCH_BIT  = 4;
   localparam int PORT_COUNT_LSB    = 0;

   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic [15:0] VERSION_RESET      = 16'h0100;
   localparam logic [7:0]  CAP_LEN_RESET      = 8'h20;
   localparam logic [3:0]  CC_COUNT_RESET     = 4'h1;
   localparam logic [3:0]  PPC_COUNT_RESET    = 4'h2;
   localparam logic        ROUTE_METHOD_RESET = 1'b1;
   localparam logic        POWER_SW_RESET     = 1'b1;
   localparam logic [3:0]  PORT_COUNT_RESET   = 4'h2;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic [15:0] interface_version_number;
      logic [7:0]  reserved_mid;
      logic [7:0]  capability_space_length;
   } cap_len_ver_type;

   typedef struct packed {
      logic [15:0] reserved_high;
      logic [3:0]  companion_controller_count;
      logic [3:0]  ports_per_companion;
      logic        port_routing_method;
      logic [1:0]  reserved_low;
      logic        port_power_switch_present;
      logic [3:0]  port_count;
   } structural_parameters_word_type;

   typedef struct packed {
      logic        read_strobe;
      logic [7:0]  address;
   } read_request_type;

endpackage

/* hw/cap_word_build.sv */
// Builds the two constant capability words from the structural fields
// Assumes: field values are fixed constants supplied by the top module
`timescale 1ns/1ps
module cap_word_build
   import cap_regs_pkg::*;
(
   // Structural fields
   input  wire logic [3:0]                     companion_count,
   input  wire logic [3:0]                     ports_per_comp,
   input  wire logic [3:0]                     ports_total,
   // Built words
   output cap_len_ver_type                     cap_word,
   output structural_parameters_word_type      struct_word
);

   // Reserved fields are tied to zero so they always read as zero
   always_comb begin
      cap_word.interface_version_number = VERSION_RESET;  // RULE2
      cap_word.reserved_mid             = 8'h00;          // RULE4
      cap_word.capability_space_length  = CAP_LEN_RESET;  // RULE3
      struct_word.reserved_high              = 16'h0000;  // RULE4
      struct_word.companion_controller_count = companion_count;  // RULE5
      struct_word.ports_per_companion        = ports_per_comp;   // RULE8
      struct_word.port_routing_method        = ROUTE_METHOD_RESET;  // RULE11
      struct_word.reserved_low               = 2'h0;
      struct_word.port_power_switch_present  = POWER_SW_RESET;  // RULE13
      struct_word.port_count                 = ports_total;     // RULE14
   end

endmodule // cap_word_build

/* hw/cap_read_mux.sv */
// Read selector for the capability bank
// Assumes: address is a byte offset; unmapped offsets read as zero
`timescale 1ns/1ps
module cap_read_mux
   import cap_regs_pkg::*;
(
   // Request
   input  wire logic [7:0]                     address,
   // Words
   input  cap_len_ver_type                     cap_word,
   input  structural_parameters_word_type      struct_word,
   // Result
   output logic [31:0]                         read_value,
   output logic                                hit
);

   // Decode the two mapped offsets
   always_comb begin
      read_value = 32'h0000_0000;
      hit        = 1'b0;
      unique case (address)
         CAP_LEN_VER_OFFSET: begin
            read_value = cap_word;  // RULE1
            hit        = 1'b1;
         end
         STRUCT_PARAMS_OFFSET: begin
            read_value = struct_word;  // RULE1
            hit        = 1'b1;
         end
         default: begin
            read_value = 32'h0000_0000;
            hit        = 1'b0;
         end
      endcase
   end

endmodule // cap_read_mux

/* test/usb_host_capability_regs_props.sv */
// Checker for the capability bank read port
// Assumes: bound to the top module, one clock domain
`timescale 1ns/1ps
module usb_host_capability_regs_props (
   // Clock, reset
   input wire logic        REF_CLK,
   input wire logic        NRST,
   // Requests
   input wire logic        RD_STROBE,
   input wire logic [7:0]  RD_ADDR,
   input wire logic        WR_STROBE,
   // Answers
   input wire logic [31:0] RD_DATA,
   input wire logic        RD_VALID,
   input wire logic        RD_HIT,
   input wire logic        HANDOFF_SUPPORTED,
   input wire logic        HS_ONLY
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // ****
   // Read steps
   // ****
   sequence s_rd(logic [7:0] a);
      RD_STROBE && RD_ADDR == a;
   endsequence
   sequence s_ans(logic [31:0] d);
      RD_VALID && RD_HIT && RD_DATA == d;
   endsequence
   a_answer_next: assert property (RD_STROBE |=> RD_VALID) else $error("no answer");
   a_no_spurious: assert property (!RD_STROBE |=> !RD_VALID) else $error("extra answer");
   a_cap_word: assert property (s_rd(8'h00) |=> s_ans(32'h01000020))
      else $error("bad word 0");
   a_struct_word: assert property (s_rd(8'h04) |=> s_ans(32'h00001292))
      else $error("bad word 4");
   a_unmapped_zero: assert property (RD_STROBE && RD_ADDR != 8'h00 && RD_ADDR != 8'h04
      |=> RD_DATA == 32'h0 && !RD_HIT) else $error("unmapped read");
   a_data_holds: assert property (!RD_STROBE |=> $stable(RD_DATA) && $stable(RD_HIT))
      else $error("data moved");
   a_write_inert: assert property (WR_STROBE && !RD_STROBE |=> $stable(RD_DATA))
      else $error("write took effect");
   a_handoff_level: assert property ($past(NRST) |-> HANDOFF_SUPPORTED && !HS_ONLY)
      else $error("status level");
endmodule // usb_host_capability_regs_props
bind usb_host_capability_regs usb_host_capability_regs_props i_usb_host_capability_regs_props (
   .REF_CLK(REF_CLK), .NRST(NRST), .RD_STROBE(RD_STROBE), .RD_ADDR(RD_ADDR),
   .WR_STROBE(WR_STROBE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_HIT(RD_HIT),
   .HANDOFF_SUPPORTED(HANDOFF_SUPPORTED), .HS_ONLY(HS_ONLY));

/* test/usb_host_capability_regs_tb.sv */
// Self-checking bench for the capability bank
// Assumes: answers come one cycle after each read strobe
`timescale 1ns/1ps
module usb_host_capability_regs_tb;
   import cap_regs_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        rd_strobe = 1'b0;
   logic [7:0]  rd_addr = 8'h00;
   logic        wr_strobe = 1'b0;
   logic [7:0]  wr_addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic [31:0] rd_data;
   logic        rd_valid, rd_hit, handoff, hs_only;
   logic [32:0] notes[$];
   int          n_mismatch = 0;
   int          checks_done = 0;
   usb_host_capability_regs i_usb_host_capability_regs (
      .REF_CLK(ref_clk), .NRST(nrst), .RD_STROBE(rd_strobe), .RD_ADDR(rd_addr),
      .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_DATA(rd_data),
      .RD_VALID(rd_valid), .RD_HIT(rd_hit), .HANDOFF_SUPPORTED(handoff), .HS_ONLY(hs_only));
   // Clock
   always #5 ref_clk = ~ref_clk;
   task automatic chk(logic [32:0] seen, logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One bench cycle; a read notes its {hit, data} expectation
   task automatic step(logic s, logic [7:0] a, logic w, logic [31:0] d);
      @(posedge ref_clk) #1;
      rd_strobe = s; rd_addr = a; wr_strobe = w; wr_addr = a; wr_data = d;
      if (s) notes.push_back(a == 8'h00 ? {1'b1, 32'h01000020} :
                             a == 8'h04 ? {1'b1, 32'h00001292} : 33'h0);
   endtask
   // Monitor: each answer takes the oldest note
   always @(posedge ref_clk) begin
      #2;
      if (rd_valid === 1'b1) begin
         if (notes.size() == 0) chk({rd_hit, rd_data}, 33'h1ffffffff);
         else chk({rd_hit, rd_data}, notes.pop_front());
      end
   end
   // Watchdog: tests need well under 2000 cycles
   initial begin
      #20000;
      n_mismatch++;
      results();
   end
   initial begin
      void'($urandom(32'hd94d));
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'b1;
      // Back to back, a write racing a read of the same word
      step(1, 8'h00, 1, 32'hffffffff);
      step(1, 8'h04, 1, 32'hffffffff);
      step(1, 8'h00, 0, 32'h0);
      step(1, 8'h08, 0, 32'h0);
      step(0, 8'h00, 0, 32'h0);
      chk({31'h0, handoff, hs_only}, 33'h2);
      // Software view of routing: read the structural word and group ports
      step(1, 8'h04, 0, 32'h0);
      step(0, 8'h00, 0, 32'h0);
      chk({32'h0, rd_data[7]}, 33'h1);
      for (int p = 0; p < rd_data[3:0]; p++)
         chk({32'h0, (p / rd_data[11:8]) < rd_data[15:12]}, 33'h1);
      for (int i = 0; i < 200; i++)
         step($urandom_range(0, 1), $urandom_range(0, 1) ? 8'(4 * $urandom_range(0, 1)) :
              8'($urandom), $urandom_range(0, 1), $urandom);
      step(0, 8'h00, 0, 32'h0);
      step(0, 8'h00, 0, 32'h0);
      // Second reset in mid-run clears every output
      nrst = 1'b0;
      #3 chk({rd_valid, rd_hit, handoff, hs_only, rd_data[28:0]}, 33'h0);
      step(0, 8'h00, 0, 32'h0);
      nrst = 1'b1;
      step(1, 8'h04, 0, 32'h0);
      step(0, 8'h00, 0, 32'h0);
      step(0, 8'h00, 0, 32'h0);
      chk({32'h0, notes.size() == 0}, 33'h1);
      results();
   end
endmodule // usb_host_capability_regs_tb
